//--- core/bspe_pkg.sv
// Constants for the bit-serial element array.
// Assumes one 100 MHz clock and an AHB-Lite register port.
package bspe_pkg;
  localparam int PE_COLS  = 8;
  localparam int PE_COUNT = 64;
  localparam int MEM_BITS = 512;
  // Instruction field positions
  localparam int F_INH  = 30;
  localparam int F_FTN  = 24;
  localparam int F_C1   = 23;
  localparam int F_SI   = 19;
  localparam int F_C2   = 18;
  localparam int F_SJ   = 14;
  localparam int F_CR   = 13;
  localparam int F_DEST = 9;
  // Operand sources
  localparam logic [3:0] SRC_ZERO = 4'h0;
  localparam logic [3:0] SRC_LCMP = 4'h1;
  localparam logic [3:0] SRC_NB0  = 4'h2;
  localparam logic [3:0] SRC_NB1  = 4'h3;
  localparam logic [3:0] SRC_Y    = 4'h4;
  localparam logic [3:0] SRC_X    = 4'h5;
  localparam logic [3:0] SRC_B    = 4'h6;
  localparam logic [3:0] SRC_A    = 4'h7;
  localparam logic [3:0] SRC_MEM  = 4'h8;
  // Functions
  localparam logic [3:0] FN_SENSE   = 4'h0;
  localparam logic [3:0] FN_PASS_I  = 4'h1;
  localparam logic [3:0] FN_PASS_J  = 4'h2;
  localparam logic [3:0] FN_NAND    = 4'h3;
  localparam logic [3:0] FN_NOR     = 4'h4;
  localparam logic [3:0] FN_XNOR    = 4'h5;
  localparam logic [3:0] FN_ADD     = 4'h6;
  localparam logic [3:0] FN_HCMP    = 4'h7;
  localparam logic [3:0] FN_ZLOAD   = 4'h8;
  localparam logic [3:0] FN_LD_MR   = 4'h9;
  localparam logic [3:0] FN_LD_MRSB = 4'ha;
  localparam logic [3:0] FN_ST_MR   = 4'hb;
  localparam logic [3:0] FN_ST_MRSB = 4'hc;
  // Destinations
  localparam logic [3:0] DS_XIN  = 4'h0;
  localparam logic [3:0] DS_AX   = 4'h1;
  localparam logic [3:0] DS_AXI  = 4'h2;
  localparam logic [3:0] DS_AXJ  = 4'h3;
  localparam logic [3:0] DS_Y    = 4'h4;
  localparam logic [3:0] DS_X    = 4'h5;
  localparam logic [3:0] DS_B    = 4'h6;
  localparam logic [3:0] DS_A    = 4'h7;
  localparam logic [3:0] DS_NONE = 4'h8;
  // Inhibit codes
  localparam logic [1:0] INH_OFF  = 2'h0;
  localparam logic [1:0] INH_ACT  = 2'h1;
  localparam logic [1:0] INH_SOME = 2'h2;
  localparam logic [1:0] INH_NONE = 2'h3;
  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_PAGE  = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_X_LO  = 8'h10;
  localparam logic [7:0] OFS_X_HI  = 8'h14;
  localparam logic [7:0] OFS_A_LO  = 8'h18;
  localparam logic [7:0] OFS_A_HI  = 8'h1c;
  localparam logic [7:0] OFS_Z_LO  = 8'h28;
  localparam logic [7:0] OFS_Z_HI  = 8'h2c;
  localparam logic [7:0] OFS_MSEL  = 8'h20;
  localparam logic [7:0] OFS_MDATA = 8'h24;
  localparam logic       RST_PAGE  = 1'b0;
endpackage

//--- core/bspe_pe.sv
// One bit-serial element: operand pick, function, inhibit, next state.
// Assumes the array supplies its memory reads and neighbour bits.
`timescale 1ns/1ps
module bspe_pe
  import bspe_pkg::*;
(
  input  wire logic [31:0] ins,
  input  wire logic        a,
  input  wire logic        b,
  input  wire logic        x,
  input  wire logic        y,
  input  wire logic        z,
  input  wire logic [3:0]  mr,
  input  wire logic [3:0]  sb,
  input  wire logic        mem_bit,
  input  wire logic        nb_n,
  input  wire logic        nb_e,
  input  wire logic        nb_s,
  input  wire logic        nb_w,
  input  wire logic [7:0]  byte_rd,
  input  wire logic        some,
  input  wire logic        net,
  input  wire logic        host_cmp,
  output logic             next_a,
  output logic             next_b,
  output logic             next_x,
  output logic             next_y,
  output logic             next_z,
  output logic [3:0]       next_mr,
  output logic [3:0]       next_sb,
  output logic [7:0]       wmask,
  output logic [7:0]       wbits
);

  function automatic logic pick(input logic [3:0] c, input logic n0, input logic n1,
                                input logic ra, input logic rb, input logic rx,
                                input logic ry, input logic m);
    logic v;
    v = 1'b0;
    case (c)
      SRC_NB0: v = n0;
      SRC_NB1: v = n1;
      SRC_Y:   v = ry;
      SRC_X:   v = rx;
      SRC_B:   v = rb;
      SRC_A:   v = ra;
      SRC_MEM: v = m;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  logic [3:0] ftn;
  logic [3:0] dest;
  logic       op_i;
  logic       op_j;
  logic       carry;
  logic       r;
  logic       d;
  logic       blocked;

  always_comb begin
    ftn   = ins[F_FTN +: 4];
    dest  = ins[F_DEST +: 4];
    op_i  = pick(ins[F_SI +: 4], nb_n, nb_s, a, b, x, y, mem_bit) ^ ins[F_C1];
    op_j  = pick(ins[F_SJ +: 4], nb_e, nb_w, a, b, x, y, mem_bit) ^ ins[F_C2];
    carry = (op_i & op_j) | (z & (op_i ^ op_j));
    unique case (ftn)
      FN_SENSE:  r = net;
      FN_PASS_I: r = op_i;
      FN_PASS_J: r = op_j;
      FN_NAND:   r = ~(op_i & op_j);
      FN_NOR:    r = ~(op_i | op_j);
      FN_XNOR:   r = ~(op_i ^ op_j);
      FN_ADD:    r = ~(op_i ^ op_j ^ z);
      FN_HCMP:   r = host_cmp;
      default:   r = 1'b0;
    endcase
    d = r ^ ins[F_CR];
    unique case (ins[F_INH +: 2])
      INH_OFF:  blocked = 1'b0;
      INH_ACT:  blocked = ~a;
      INH_SOME: blocked = ~a | some;
      INH_NONE: blocked = ~a | ~some;
    endcase
    next_a  = a;
    next_b  = b;
    next_x  = x;
    next_y  = y;
    next_z  = z;
    next_mr = mr;
    next_sb = sb;
    wmask   = 8'h00;
    wbits   = 8'h00;
    if (!blocked) begin
      if (ftn < FN_ZLOAD) begin
        case (dest)
          DS_XIN: next_x = d;
          DS_AX: begin
            next_a = d;
            next_x = d;
          end
          DS_AXI: begin
            next_a = d;
            next_x = op_i;
          end
          DS_AXJ: begin
            next_a = d;
            next_x = op_j;
          end
          DS_Y:    next_y = d;
          DS_X:    next_x = d;
          DS_B:    next_b = d;
          DS_A:    next_a = d;
          default: ;
        endcase
        if (ftn == FN_ADD) begin
          next_z = carry;
        end
      end else begin
        case (ftn)
          FN_ZLOAD: next_z = op_i;
          FN_LD_MR: next_mr = ins[2] ? byte_rd[7:4] : byte_rd[3:0];
          FN_LD_MRSB: begin
            next_mr = byte_rd[3:0];
            next_sb = byte_rd[7:4];
          end
          FN_ST_MR: begin
            wmask = ins[2] ? 8'hf0 : 8'h0f;
            wbits = {mr, mr};
          end
          FN_ST_MRSB: begin
            wmask = 8'hff;
            wbits = {sb, mr};
          end
          default: ;
        endcase
      end
    end
  end

endmodule

//--- core/bspe_array.sv
// Array of 64 bit-serial elements behind an AHB-Lite slave.
// Assumes one clock; instructions arrive as word writes.
//
// What this block does
// - Sixty-four identical elements in an 8 by 8 grid, each with memory and registers.
// - Each element memory holds four pages of 128 bits, 512 bits.
// - Nine-bit address: top two bits pick virtual page, low seven the bit.
// - Virtual page goes through the page map before any memory access.
// - Backing-store style access uses virtual page zero, also page mapped.
// - Constant source always reads zero and is never written.
// - Inhibit code 0 never, 1 on A low, 2 also Some, 3 also None.
// - Network reads every status bit whatever the inhibit field.
// - Neighbour sources return the addressed memory bit of the adjacent element.
// - Each operand has its own complement bit; result has its own too.
// - Status-input destination writes status and precharges the network.
// - A,X writes both; variants write A and load X from I or J.
// - Functions above 8 ignore first complement; issuer sets destination 8.
// - Functions 0-7: sense, I, J, NAND, NOR, XNOR, inverted sum, host bit.
// - Sense loads network state from mesh, status, precharge; result complement applies.
// - Carry load copies first operand with its complement, no result complement.
// - Nibble transfers move four aligned bits chosen by address bits 7 to 2.
// - Byte transfers use bits 7 to 3; low nibble in mesh, high in buffer.
// - Mesh register steers the network; its transfers reach only pages V0, V1.
// - Page map loads a value 0 or 1 choosing where low addresses map.
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module bspe_array
  import bspe_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  typedef struct packed {
    logic [PE_COUNT-1:0]      a;
    logic [PE_COUNT-1:0]      b;
    logic [PE_COUNT-1:0]      x;
    logic [PE_COUNT-1:0]      y;
    logic [PE_COUNT-1:0]      z;
    logic [PE_COUNT-1:0][3:0] mr;
    logic [PE_COUNT-1:0][3:0] sb;
    logic                     page_map;
    logic                     host_cmp;
    logic                     precharged;
    logic                     wr_pend;
    logic                     rd_pend;
    logic                     ready;
    logic                     resp;
    logic [7:0]               bus_addr;
    logic [7:0]               mem_sel;
    logic [31:0]              rdata;
  } bspe_state_t;

  bspe_state_t         st;
  bspe_state_t         next_st;
  logic [MEM_BITS-1:0] mem [PE_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  logic [31:0] ins;
  logic        exec;
  logic [1:0]  ins_inh;
  logic [3:0]  ins_ftn;
  logic [3:0]  ins_si;
  logic [3:0]  ins_sj;
  logic [3:0]  ins_dest;
  logic        ins_c1;
  logic        ins_c2;
  logic        ins_cr;
  logic [8:0]  pidx;
  logic [8:0]  bbase;
  logic [8:0]  host_base;
  logic        some;
  logic        host_wr;

  assign ins      = hwdata;
  assign exec     = ce && st.wr_pend && (st.bus_addr == OFS_INSTR);
  assign host_wr  = ce && st.wr_pend && (st.bus_addr == OFS_MDATA);
  assign ins_inh  = ins[F_INH +: 2];
  assign ins_ftn  = ins[F_FTN +: 4];
  assign ins_c1   = ins[F_C1];
  assign ins_si   = ins[F_SI +: 4];
  assign ins_c2   = ins[F_C2];
  assign ins_sj   = ins[F_SJ +: 4];
  assign ins_cr   = ins[F_CR];
  assign ins_dest = ins[F_DEST +: 4];
  // Page-mapped bit address for single-bit access
  assign pidx = {ins[8] ^ st.page_map, ins[7], ins[6:0]};
  // Aligned byte base, limited to V0 and V1
  assign bbase = {st.page_map, ins[7], ins[6:3], 3'h0};
  // Host window into virtual page zero
  assign host_base = {st.page_map, 1'b0, st.mem_sel[7:6], 5'h00};
  assign some = |st.x;

  ////////////////////////////////////////////////////////////////////////////
  // Element grid

  logic [PE_COUNT-1:0]      sbit;
  logic [PE_COUNT-1:0]      nb_n;
  logic [PE_COUNT-1:0]      nb_e;
  logic [PE_COUNT-1:0]      nb_s;
  logic [PE_COUNT-1:0]      nb_w;
  logic [PE_COUNT-1:0]      net;
  logic [PE_COUNT-1:0]      pe_a;
  logic [PE_COUNT-1:0]      pe_b;
  logic [PE_COUNT-1:0]      pe_x;
  logic [PE_COUNT-1:0]      pe_y;
  logic [PE_COUNT-1:0]      pe_z;
  logic [PE_COUNT-1:0][3:0] pe_mr;
  logic [PE_COUNT-1:0][3:0] pe_sb;
  logic [PE_COUNT-1:0][7:0] byte_rd;
  logic [PE_COUNT-1:0][7:0] wmask;
  logic [PE_COUNT-1:0][7:0] wbits;

  for (genvar p = 0; p < PE_COUNT; p++) begin : g_pe
    localparam int ROW = p / PE_COLS;
    localparam int COL = p % PE_COLS;
    localparam int NI  = (ROW > 0) ? p - PE_COLS : p;
    localparam int SI  = (ROW < PE_COLS - 1) ? p + PE_COLS : p;
    localparam int EI  = (COL < PE_COLS - 1) ? p + 1 : p;
    localparam int WI  = (COL > 0) ? p - 1 : p;
    localparam logic HN = (ROW > 0);
    localparam logic HS = (ROW < PE_COLS - 1);
    localparam logic HE = (COL < PE_COLS - 1);
    localparam logic HW = (COL > 0);
    assign sbit[p]    = mem[p][pidx];
    assign byte_rd[p] = mem[p][bbase +: 8];
    assign nb_n[p]    = HN & sbit[NI];
    assign nb_s[p]    = HS & sbit[SI];
    assign nb_e[p]    = HE & sbit[EI];
    assign nb_w[p]    = HW & sbit[WI];
    // One-hop region sense through closed mesh switches
    assign net[p] = st.precharged & (st.x[p] | (st.mr[p][0] & HN & st.x[NI]) |
                    (st.mr[p][1] & HE & st.x[EI]) | (st.mr[p][2] & HS & st.x[SI]) |
                    (st.mr[p][3] & HW & st.x[WI]));
    bspe_pe u_pe (
      .ins      (ins),
      .a        (st.a[p]),
      .b        (st.b[p]),
      .x        (st.x[p]),
      .y        (st.y[p]),
      .z        (st.z[p]),
      .mr       (st.mr[p]),
      .sb       (st.sb[p]),
      .mem_bit  (sbit[p]),
      .nb_n     (nb_n[p]),
      .nb_e     (nb_e[p]),
      .nb_s     (nb_s[p]),
      .nb_w     (nb_w[p]),
      .byte_rd  (byte_rd[p]),
      .some     (some),
      .net      (net[p]),
      .host_cmp (st.host_cmp),
      .next_a   (pe_a[p]),
      .next_b   (pe_b[p]),
      .next_x   (pe_x[p]),
      .next_y   (pe_y[p]),
      .next_z   (pe_z[p]),
      .next_mr  (pe_mr[p]),
      .next_sb  (pe_sb[p]),
      .wmask    (wmask[p]),
      .wbits    (wbits[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [31:0] rd_mux;

  always_comb begin
    case (st.bus_addr)
      OFS_PAGE:  rd_mux = {31'h0, st.page_map};
      OFS_CTRL:  rd_mux = {31'h0, st.host_cmp};
      OFS_STAT:  rd_mux = {29'h0, st.page_map, st.precharged, some};
      OFS_X_LO:  rd_mux = st.x[31:0];
      OFS_X_HI:  rd_mux = st.x[63:32];
      OFS_A_LO:  rd_mux = st.a[31:0];
      OFS_A_HI:  rd_mux = st.a[63:32];
      OFS_Z_LO:  rd_mux = st.z[31:0];
      OFS_Z_HI:  rd_mux = st.z[63:32];
      OFS_MSEL:  rd_mux = {24'h0, st.mem_sel};
      OFS_MDATA: rd_mux = mem[st.mem_sel[5:0]][host_base +: 32];
      default:   rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.wr_pend = 1'b0;
      if (st.wr_pend) begin
        case (st.bus_addr)
          OFS_PAGE: next_st.page_map = hwdata[0];
          OFS_CTRL: next_st.host_cmp = hwdata[0];
          OFS_MSEL: next_st.mem_sel  = hwdata[7:0];
          default:  ;
        endcase
      end
      if (st.rd_pend) begin
        next_st.rdata   = rd_mux;
        next_st.rd_pend = 1'b0;
        next_st.ready   = 1'b1;
      end
      if (hsel && hready && htrans[1]) begin
        next_st.bus_addr = haddr[7:0];
        if (hwrite) begin
          next_st.wr_pend = 1'b1;
        end else begin
          next_st.rd_pend = 1'b1;
          next_st.ready   = 1'b0;
        end
      end
      if (exec) begin
        next_st.a  = pe_a;
        next_st.b  = pe_b;
        next_st.x  = pe_x;
        next_st.y  = pe_y;
        next_st.z  = pe_z;
        next_st.mr = pe_mr;
        next_st.sb = pe_sb;
        if (ins_ftn < FN_ZLOAD && ins_dest == DS_XIN) begin
          next_st.precharged = 1'b1;
        end else if (ins_ftn == FN_SENSE) begin
          next_st.precharged = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;
      st.ready    <= 1'b1;
      st.page_map <= RST_PAGE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Element memory

  always_ff @(posedge hclk) begin
    if (exec) begin
      for (int p = 0; p < PE_COUNT; p++) begin
        for (int k = 0; k < 8; k++) begin
          if (wmask[p][k]) begin
            mem[p][{bbase[8:3], 3'(k)}] <= wbits[p][k];
          end
        end
      end
    end
    if (host_wr) begin
      mem[st.mem_sel[5:0]][host_base +: 32] <= hwdata;
    end
  end

  assign hreadyout = st.ready;
  assign hresp     = st.resp;
  assign hrdata    = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_clean;
    exec && ins_inh == INH_OFF;
  endsequence

  sequence s_zero_i;
    s_clean ##0 ins_si == SRC_ZERO && !ins_cr;
  endsequence

  a_inhibit_hold: assert property (
    exec && ins_inh == INH_ACT && !st.a[0]
    |=> $stable(st.x[0]) && $stable(st.y[0]) && $stable(st.z[0]) && $stable(st.mr[0]))
    else $error("inhibited element changed");

  a_some_inhibit: assert property (
    exec && ins_inh == INH_SOME && (|st.x) |=> $stable(st.a) && $stable(st.x))
    else $error("some response failed to inhibit");

  a_zero_src: assert property (
    s_zero_i ##0 ins_ftn == FN_PASS_I && !ins_c1 && ins_dest == DS_Y |=> st.y == '0)
    else $error("zero source not zero");

  a_compl_in: assert property (
    s_zero_i ##0 ins_ftn == FN_PASS_I && ins_c1 && ins_dest == DS_B |=> &st.b)
    else $error("operand complement lost");

  a_xin_prech: assert property (
    exec && ins_ftn < FN_ZLOAD && ins_dest == DS_XIN |=> st.precharged)
    else $error("precharge not set");

  a_carry_set: assert property (
    s_zero_i ##0 ins_ftn == FN_ADD && ins_sj == SRC_ZERO && ins_c1 && ins_c2 |=> &st.z)
    else $error("carry out not stored");

  a_zload_cpy: assert property (
    exec && ins_inh == INH_OFF && ins_ftn == FN_ZLOAD && ins_si == SRC_ZERO
    |=> st.z == {PE_COUNT{$past(ins_c1)}})
    else $error("carry load wrong");

  a_page_load: assert property (
    ce && st.wr_pend && st.bus_addr == OFS_PAGE |=> st.page_map == $past(hwdata[0]))
    else $error("page map not loaded");

  a_sense_clr: assert property (
    exec && ins_ftn == FN_SENSE && ins_dest != DS_XIN |=> !st.precharged)
    else $error("precharge not cleared by sense");

  a_axi_old: assert property (
    s_clean ##0 ins_ftn < FN_ZLOAD && ins_dest == DS_AXI && ins_si == SRC_A && !ins_c1
    |=> st.x == $past(st.a))
    else $error("variant copy used new activity");

  a_read_wait: assert property (
    ce && hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_resp_okay: assert property (!hresp)
    else $error("response not okay");

endmodule

//--- tb/bspe_acu.sv
// Array controller model: issues single AHB-Lite word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module bspe_acu (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hung
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hung   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Bounded wait for hready sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) hung <= 1'b1;
  endtask
  // One word transfer; instruction words keep one shared address
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

//--- tb/bit_serial_pe_array_tb_top.sv
// Self-checking bench for the element array over AHB-Lite.
// Assumes the controller model drives the bus at 100 MHz.
`timescale 1ns/1ps
module bit_serial_pe_array_tb_top
  import bspe_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic        hung;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  int          miscompares;
  int          n_compared;
  bspe_acu acu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));
  bspe_array DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] op(logic [1:0] h, logic [3:0] f, logic c1, logic [3:0] si, logic c2,
                                     logic [3:0] sj, logic cr, logic [3:0] d, logic [8:0] ad);
    return {h, 2'h0, f, c1, si, c2, sj, cr, d, ad};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acu.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    acu.xfer(1'b0, a, 32'h0, q);
    chk(nm, e & m, q & m);
  endtask
  task automatic both(input string nm, input logic [7:0] a, input logic e);
    rc(nm, a, {32{e}}, 32'hffffffff);
    rc(nm, a + 8'h04, {32{e}}, 32'hffffffff);
  endtask
  task automatic ax(input logic ea, input logic ex);
    both("a", OFS_A_LO, ea);
    both("x", OFS_X_LO, ex);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rc("stat", OFS_STAT, 32'h0, 32'hffffffff);
    wr(OFS_PAGE, 32'h1);
    rc("page", OFS_PAGE, 32'h1, 32'h1);
    rc("stat_pg", OFS_STAT, 32'h4, 32'h4);
    wr(OFS_PAGE, 32'h0);
    rc("unmapped", 8'h30, 32'h0, 32'hffffffff);
    rc("instr", OFS_INSTR, 32'h0, 32'hffffffff);
    $display("done regs");
  endtask
  task automatic t_logic();
    logic i, j, r;
    for (int f = 1; f < 6; f++) begin
      for (int c = 0; c < 4; c++) begin
        i = c[0];
        j = c[1];
        case (f)
          1: r = i;
          2: r = j;
          3: r = ~(i & j);
          4: r = ~(i | j);
          default: r = ~(i ^ j);
        endcase
        wr(OFS_INSTR, op(INH_OFF, f[3:0], i, SRC_ZERO, j, SRC_ZERO, f[0], DS_X, 9'h0));
        both("x_fn", OFS_X_LO, r ^ f[0]);
      end
    end
    wr(OFS_CTRL, 32'h1);
    rc("ctrl", OFS_CTRL, 32'h1, 32'h1);
    wr(OFS_INSTR, op(INH_OFF, FN_HCMP, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
    both("x_hcmp", OFS_X_LO, 1'b1);
    $display("done logic");
  endtask
  task automatic t_add();
    wr(OFS_INSTR, op(INH_OFF, FN_ZLOAD, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b1, DS_NONE, 9'h0));
    both("z_load", OFS_Z_LO, 1'b1);
    both("x_keep", OFS_X_LO, 1'b1);
    wr(OFS_INSTR, op(INH_OFF, FN_ADD, 1'b1, SRC_ZERO, 1'b1, SRC_ZERO, 1'b0, DS_X, 9'h0));
    both("x_add1", OFS_X_LO, 1'b0);
    both("z_add1", OFS_Z_LO, 1'b1);
    wr(OFS_INSTR, op(INH_OFF, FN_ADD, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b1, DS_X, 9'h0));
    both("x_add2", OFS_X_LO, 1'b1);
    both("z_add2", OFS_Z_LO, 1'b0);
    $display("done add");
  endtask
  task automatic t_inh();
    logic [11:0] hv;
    logic [5:0]  v;
    logic [5:0]  e;
    hv = 12'h1eb;
    v  = 6'h33;
    e  = 6'h26;
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_A, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
    for (int k = 0; k < 6; k++) begin
      if (k == 4) wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_A, 9'h0));
      wr(OFS_INSTR, op(hv[2*k+:2], FN_PASS_I, v[k], SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
      both("x_inh", OFS_X_LO, e[k]);
    end
    $display("done inhibit");
  endtask
  task automatic t_dest();
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_A, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_J, 1'b0, SRC_A, 1'b0, SRC_ZERO, 1'b0, DS_AXI, 9'h0));
    ax(1'b0, 1'b1);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_AXJ, 9'h0));
    ax(1'b1, 1'b0);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_AX, 9'h0));
    ax(1'b0, 1'b0);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_AX, 9'h0));
    ax(1'b1, 1'b1);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_B, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_Y, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_Y, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_XNOR, 1'b0, SRC_B, 1'b0, SRC_Y, 1'b0, DS_X, 9'h0));
    both("x_by", OFS_X_LO, 1'b0);
    $display("done dest");
  endtask
  task automatic t_net();
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_XIN, 9'h0));
    rc("stat_pre", OFS_STAT, 32'h2, 32'h7);
    wr(OFS_INSTR, op(INH_OFF, FN_SENSE, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b1, DS_X, 9'h0));
    both("x_sense", OFS_X_LO, 1'b1);
    rc("stat_sns", OFS_STAT, 32'h1, 32'h7);
    wr(OFS_INSTR, op(INH_OFF, FN_SENSE, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
    both("x_nopre", OFS_X_LO, 1'b0);
    $display("done network");
  endtask
  task automatic t_mem();
    wr(OFS_MSEL, 32'h9);
    wr(OFS_MDATA, 32'ha5);
    rc("mdata", OFS_MDATA, 32'ha5, 32'hffffffff);
    wr(OFS_PAGE, 32'h1);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b1, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h0));
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_MEM, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h101));
    rc("x_mem", OFS_X_LO, 32'h0, 32'h200);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_NB0, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h100));
    rc("x_north", OFS_X_LO, 32'h20000, 32'h200ff);
    wr(OFS_INSTR, op(INH_OFF, FN_PASS_I, 1'b0, SRC_NB1, 1'b0, SRC_ZERO, 1'b0, DS_X, 9'h100));
    rc("x_south", OFS_X_LO, 32'h2, 32'h2);
    rc("x_edge", OFS_X_HI, 32'h0, 32'hff000000);
    wr(OFS_PAGE, 32'h0);
    wr(OFS_INSTR, op(INH_OFF, FN_LD_MR, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_NONE, 9'h005));
    wr(OFS_INSTR, op(INH_OFF, FN_ST_MR, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_NONE, 9'h00b));
    rc("nibble", OFS_MDATA, 32'haa5, 32'hffffffff);
    wr(OFS_INSTR, op(INH_OFF, FN_LD_MRSB, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_NONE, 9'h007));
    wr(OFS_INSTR, op(INH_OFF, FN_ST_MRSB, 1'b0, SRC_ZERO, 1'b0, SRC_ZERO, 1'b0, DS_NONE, 9'h013));
    rc("byte", OFS_MDATA, 32'ha50aa5, 32'hffffffff);
    $display("done memory");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hung) begin
    miscompares++;
    complete_run();
  end
  initial begin
    hresetn     = 1'b0;
    ce          = 1'b1;
    miscompares = 0;
    n_compared  = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_logic();
    t_add();
    t_inh();
    t_dest();
    t_net();
    t_mem();
    complete_run();
  end
endmodule
